// ===== common/opc_regs.svh
`ifndef OPC_REGS_SVH
`define OPC_REGS_SVH
// What this block does
// [R1] Modulated low share of carrier: 00=1/2, 01=1/4, 10=1/8, 11=1/16.
// [R2] Receive pin feeds the UART comparator path at 0, general pin one at 1.
// [R3] Receive inversion acts on the UART path only, never on pin one.
// [R4] Transmit pin is UART, general pin two or energy pulse; code 11 unused.
// [R5] Transmit inversion is applied before any modulation.
// [R6] With modulation on, low transmit intervals become carrier; highs stay.
// [R7] A low energy pulse ends within (2 * width limit + 1) units; reset FF.
// [R8] Width unit is the pacing interval, or one 397 us sample when zero.
// [R9] Width limit of 255 disables the limit at pacing zero; with pacing set, the pulse lasts one unit.
// [R10] Software sets pacing interval to 81 before using paced pulses.
// [R11] Pacing interval zero bypasses the queue; pulses leave at once.
// [R12] Energy pulse is active low; polarity bit set makes it active high.
// [R13] Carrier comes from a free-running counter compared with the duty.
// [R14] General pin mode passes data and enable with no inversion or carrier.

// Register indices; byte address is four times the index
`define OPC_IDX_PULSE_POL 14'h2004
`define OPC_IDX_TX_SEL    14'h2007
`define OPC_IDX_OPT_CTRL  14'h2008
`define OPC_IDX_WIDTH_LIM 14'h2080
`define OPC_IDX_PACING    14'h2081
`define OPC_IDX_STATUS    14'h2090

// Field positions
`define OPC_BIT_PULSE_POL 6
`define OPC_POS_TX_FUNC   6
`define OPC_POS_DUTY      0
`define OPC_BIT_RX_FUNC   5
`define OPC_BIT_RX_INV    4
`define OPC_BIT_TX_MOD    1
`define OPC_BIT_TX_INV    0

// Reset values
`define OPC_RST_BIT       1'b0
`define OPC_RST_FIELD2    2'b00
`define OPC_RST_WIDTH_LIM 8'hFF
`define OPC_RST_PACING    8'h00
`define OPC_NO_LIMIT      8'hFF

// Timing
`define OPC_CLK_NS        20
`define OPC_SAMPLE_NS     397000
`define OPC_SAMPLE_CYCLES (`OPC_SAMPLE_NS / `OPC_CLK_NS)
`define OPC_CARRIER_W     10
`endif

// ===== common/opc_pkg.sv
package opc_pkg;
	// Transmit pin function codes
	typedef enum logic [1:0] {
		TXF_UART  = 2'b00,
		TXF_GPIO  = 2'b01,
		TXF_PULSE = 2'b10,
		TXF_RSVD  = 2'b11
	} opc_txfn_t;

	// Pulse shaper states
	typedef enum logic [1:0] {
		SH_IDLE   = 2'b00,
		SH_ACTIVE = 2'b01,
		SH_CUT    = 2'b10
	} opc_shstate_t;

	// Software configuration
	typedef struct packed {
		logic       pulsePol;
		opc_txfn_t  txFunc;
		logic [1:0] txDuty;
		logic       rxFunc;
		logic       rxInv;
		logic       txMod;
		logic       txInv;
		logic [7:0] widthLim;
		logic [7:0] pacing;
	} opc_cfg_t;
endpackage : opc_pkg

// ===== verilog/opc_tx_modulator.sv
`timescale 1ns/10ps
`include "opc_regs.svh"
module opc_tx_modulator import opc_pkg::*; #(
	parameter int CARRIER_W = `OPC_CARRIER_W
) (
	input  wire logic     clk,
	input  wire logic     rst_b,
	input  wire opc_cfg_t cfg,
	input  wire logic     txData,
	output logic          txOut
);
	logic [CARRIER_W-1:0] carrier_r;
	logic [3:0]           phase;
	logic [3:0]           lowSpan;
	logic                 carrierLevel;
	logic                 txPost;

	// Free-running carrier counter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			carrier_r <= '0;
		end else begin
			carrier_r <= carrier_r + 1'b1; // [R13]
		end
	end

	// Low span in sixteenths of a period
	assign phase = carrier_r[CARRIER_W-1 -: 4];
	assign lowSpan = 4'(4'h8 >> cfg.txDuty); // [R1]
	assign carrierLevel = (phase >= lowSpan); // [R13]

	// Inversion first, then carrier on low intervals
	assign txPost = txData ^ cfg.txInv; // [R5]
	assign txOut = (cfg.txMod && !txPost) ? carrierLevel : txPost; // [R6]
endmodule : opc_tx_modulator

// ===== verilog/opc_pulse_shaper.sv
`timescale 1ns/10ps
`include "opc_regs.svh"
module opc_pulse_shaper import opc_pkg::*; #(
	parameter int SAMPLE_CYCLES = `OPC_SAMPLE_CYCLES,
	parameter int PEND_W        = 4
) (
	input  wire logic     clk,
	input  wire logic     rst_b,
	input  wire opc_cfg_t cfg,
	input  wire logic     ceLevel,
	output logic          pulseActive,
	output logic [PEND_W-1:0] pendCount
);
	localparam int SAMP_W = $clog2(SAMPLE_CYCLES + 1);

	logic [SAMP_W-1:0] sampCnt_r;
	logic [7:0]        unitCnt_r;
	logic [8:0]        widthCnt_r;
	logic [8:0]        maxUnits;
	logic [PEND_W-1:0] pend_r;
	logic              ceLevel_r;
	logic              sampTick;
	logic              unitTick;
	logic              fifoMode;
	logic              noLimit;
	logic              reached;
	logic              widthDone;
	logic              ceRise;
	logic              startPulse;
	opc_shstate_t      state_r;

	assign fifoMode = (cfg.pacing != 8'h00); // [R11]
	assign noLimit = (cfg.widthLim == `OPC_NO_LIMIT); // [R9]
	assign maxUnits = {cfg.widthLim, 1'b1}; // [R7]
	assign sampTick = (sampCnt_r == SAMP_W'(SAMPLE_CYCLES - 1));
	assign unitTick = sampTick &&
		(!fifoMode || unitCnt_r == cfg.pacing - 8'h01); // [R8]
	assign reached = (widthCnt_r + 9'h001 >= maxUnits);
	assign widthDone = unitTick && (fifoMode ? (noLimit || reached)
		: (!noLimit && reached)); // [R7] [R9]
	assign ceRise = ceLevel && !ceLevel_r;
	assign startPulse = fifoMode && state_r == SH_IDLE && unitTick &&
		pend_r != '0;
	assign pulseActive = (state_r == SH_ACTIVE);
	assign pendCount = pend_r;

	// Sample period timer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sampCnt_r <= '0;
		end else if (sampTick) begin
			sampCnt_r <= '0;
		end else begin
			sampCnt_r <= sampCnt_r + 1'b1;
		end
	end

	// Pacing interval divider in samples
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			unitCnt_r <= 8'h00;
		end else if (!fifoMode || unitTick) begin
			unitCnt_r <= 8'h00;
		end else if (sampTick) begin
			unitCnt_r <= unitCnt_r + 8'h01;
		end
	end

	// Edge detect and queued pulse count
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ceLevel_r <= 1'b0;
			pend_r <= '0;
		end else begin
			ceLevel_r <= ceLevel;
			if (!fifoMode) begin
				pend_r <= '0;
			end else if (ceRise && !startPulse && pend_r != '1) begin
				pend_r <= pend_r + 1'b1;
			end else if (startPulse && !ceRise) begin
				pend_r <= pend_r - 1'b1;
			end
		end
	end

	// Width counter in units
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			widthCnt_r <= 9'h000;
		end else if (state_r != SH_ACTIVE) begin
			widthCnt_r <= 9'h000;
		end else if (unitTick && widthCnt_r != 9'h1FF) begin
			widthCnt_r <= widthCnt_r + 9'h001;
		end
	end

	// Pulse state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= SH_IDLE;
		end else begin
			case (state_r)
				SH_IDLE: begin
					if (fifoMode ? startPulse : ceLevel) begin
						state_r <= SH_ACTIVE; // [R11]
					end
				end
				SH_ACTIVE: begin
					if (widthDone) begin
						state_r <= fifoMode ? SH_IDLE : SH_CUT; // [R7]
					end else if (!fifoMode && !ceLevel) begin
						state_r <= SH_IDLE;
					end
				end
				SH_CUT: begin
					if (!ceLevel) begin
						state_r <= SH_IDLE;
					end
				end
				default: begin
					state_r <= SH_IDLE;
				end
			endcase
		end
	end
endmodule : opc_pulse_shaper

// ===== verilog/opc_top.sv
`timescale 1ns/10ps
`include "opc_regs.svh"
module opc_top import opc_pkg::*; #(
	parameter int SAMPLE_CYCLES = `OPC_SAMPLE_CYCLES,
	parameter int CARRIER_W     = `OPC_CARRIER_W,
	parameter int PEND_W        = 4
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [15:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        uartTxData,
	output logic             uartRxData,
	input  wire logic        ceWpulse,
	input  wire logic        gpOneOut,
	input  wire logic        gpOneOe,
	output logic             gpOneIn,
	input  wire logic        gpTwoOut,
	input  wire logic        gpTwoOe,
	output logic             gpTwoIn,
	input  wire logic        optRxIn,
	output logic             optRxOut,
	output logic             optRxOe,
	input  wire logic        optTxIn,
	output logic             optTxOut,
	output logic             optTxOe,
	output logic             energyPulse
);
	opc_cfg_t          cfg_r;
	logic [1:0]        pinRaw;
	logic [1:0]        syncA_r;
	logic [1:0]        syncB_r;
	logic              rxSync;
	logic              txSync;
	logic              accessPh;
	logic              doneXfer;
	logic              wrEn;
	logic              mapped;
	logic [7:0]        rdByte;
	logic              modOut;
	logic              pulseActive;
	logic [PEND_W-1:0] pendCount;
	logic              pulseLevel;
	logic              txLevel;
	logic              txEnable;
	logic [31:0]       prdata_r;
	logic              pready_r;
	logic              pslverr_r;
	logic              uartRx_r;
	logic              gpOneIn_r;
	logic              gpTwoIn_r;
	logic              optRxOut_r;
	logic              optRxOe_r;
	logic              optTxOut_r;
	logic              optTxOe_r;
	logic              energyPulse_r;
	logic              wrPol;
	logic              wrTxSel;
	logic              wrCtrl;
	logic              wrLim;
	logic              wrPace;
	logic [7:0]        statusByte;

	// Byte address match for a register index
	function automatic logic isReg(
		input logic [15:0] addr,
		input logic [13:0] idx
	);
		isReg = (addr == {idx, 2'b00});
	endfunction : isReg

	// Two-stage synchronisers for both optical pins
	assign pinRaw = {optTxIn, optRxIn};
	generate
		for (genvar i = 0; i < 2; i++) begin : gSync
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					syncA_r[i] <= 1'b1;
					syncB_r[i] <= 1'b1;
				end else begin
					syncA_r[i] <= pinRaw[i];
					syncB_r[i] <= syncA_r[i];
				end
			end
		end
	endgenerate
	assign rxSync = syncB_r[0];
	assign txSync = syncB_r[1];

	// Bus phase decode
	assign accessPh = psel && penable;
	assign doneXfer = accessPh && pready_r;
	assign wrEn = doneXfer && pwrite && !pslverr_r;
	assign mapped = isReg(paddr, `OPC_IDX_PULSE_POL) ||
		isReg(paddr, `OPC_IDX_TX_SEL) ||
		isReg(paddr, `OPC_IDX_OPT_CTRL) ||
		isReg(paddr, `OPC_IDX_WIDTH_LIM) ||
		isReg(paddr, `OPC_IDX_PACING) ||
		isReg(paddr, `OPC_IDX_STATUS);

	// Per-register write strobes
	assign wrPol = wrEn && isReg(paddr, `OPC_IDX_PULSE_POL);
	assign wrTxSel = wrEn && isReg(paddr, `OPC_IDX_TX_SEL);
	assign wrCtrl = wrEn && isReg(paddr, `OPC_IDX_OPT_CTRL);
	assign wrLim = wrEn && isReg(paddr, `OPC_IDX_WIDTH_LIM);
	assign wrPace = wrEn && isReg(paddr, `OPC_IDX_PACING);

	// Status byte: queue depth, pin levels, pulse state
	assign statusByte = {
		4'(pendCount),
		1'b0,
		optTxOut_r,
		rxSync,
		pulseActive
	};

	// One wait state, then ready with error for unmapped
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= accessPh && !pready_r;
			pslverr_r <= accessPh && !pready_r && !mapped;
		end
	end

	// Configuration writes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_r.pulsePol <= `OPC_RST_BIT;
			cfg_r.txFunc <= TXF_UART;
			cfg_r.txDuty <= `OPC_RST_FIELD2;
			cfg_r.rxFunc <= `OPC_RST_BIT;
			cfg_r.rxInv <= `OPC_RST_BIT;
			cfg_r.txMod <= `OPC_RST_BIT;
			cfg_r.txInv <= `OPC_RST_BIT;
			cfg_r.widthLim <= `OPC_RST_WIDTH_LIM; // [R7]
			cfg_r.pacing <= `OPC_RST_PACING;
		end else begin
			if (wrPol) begin
				cfg_r.pulsePol <= pwdata[`OPC_BIT_PULSE_POL];
			end
			if (wrTxSel) begin
				cfg_r.txFunc <= opc_txfn_t'(
					pwdata[`OPC_POS_TX_FUNC +: 2]);
				cfg_r.txDuty <= pwdata[`OPC_POS_DUTY +: 2];
			end
			if (wrCtrl) begin
				cfg_r.rxFunc <= pwdata[`OPC_BIT_RX_FUNC];
				cfg_r.rxInv <= pwdata[`OPC_BIT_RX_INV];
				cfg_r.txMod <= pwdata[`OPC_BIT_TX_MOD];
				cfg_r.txInv <= pwdata[`OPC_BIT_TX_INV];
			end
			if (wrLim) begin
				cfg_r.widthLim <= pwdata[7:0];
			end
			if (wrPace) begin
				cfg_r.pacing <= pwdata[7:0];
			end
		end
	end

	// Read mux; unused bits read zero
	always_comb begin
		rdByte = 8'h00;
		if (isReg(paddr, `OPC_IDX_PULSE_POL)) begin
			rdByte[`OPC_BIT_PULSE_POL] = cfg_r.pulsePol;
		end else if (isReg(paddr, `OPC_IDX_TX_SEL)) begin
			rdByte[`OPC_POS_TX_FUNC +: 2] = cfg_r.txFunc;
			rdByte[`OPC_POS_DUTY +: 2] = cfg_r.txDuty;
		end else if (isReg(paddr, `OPC_IDX_OPT_CTRL)) begin
			rdByte[`OPC_BIT_RX_FUNC] = cfg_r.rxFunc;
			rdByte[`OPC_BIT_RX_INV] = cfg_r.rxInv;
			rdByte[`OPC_BIT_TX_MOD] = cfg_r.txMod;
			rdByte[`OPC_BIT_TX_INV] = cfg_r.txInv;
		end else if (isReg(paddr, `OPC_IDX_WIDTH_LIM)) begin
			rdByte = cfg_r.widthLim;
		end else if (isReg(paddr, `OPC_IDX_PACING)) begin
			rdByte = cfg_r.pacing;
		end else if (isReg(paddr, `OPC_IDX_STATUS)) begin
			rdByte = statusByte;
		end
	end

	// Read data captured in the wait cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_r <= 32'h0000_0000;
		end else if (accessPh && !pready_r) begin
			prdata_r <= {24'h00_0000, rdByte};
		end
	end

	// Transmit conditioning
	opc_tx_modulator #(
		.CARRIER_W (CARRIER_W)
	) uMod (
		.clk    (clk),
		.rst_b  (rst_b),
		.cfg    (cfg_r),
		.txData (uartTxData),
		.txOut  (modOut)
	);

	// Energy pulse width and pacing
	opc_pulse_shaper #(
		.SAMPLE_CYCLES (SAMPLE_CYCLES),
		.PEND_W        (PEND_W)
	) uShaper (
		.clk         (clk),
		.rst_b       (rst_b),
		.cfg         (cfg_r),
		.ceLevel     (ceWpulse),
		.pulseActive (pulseActive),
		.pendCount   (pendCount)
	);

	// Pulse polarity, low when active by default
	assign pulseLevel = cfg_r.pulsePol ? pulseActive
		: !pulseActive; // [R12]

	// Transmit pin function select
	always_comb begin
		case (cfg_r.txFunc)
			TXF_UART: begin
				txLevel = modOut; // [R4]
				txEnable = 1'b1;
			end
			TXF_GPIO: begin
				txLevel = gpTwoOut; // [R14]
				txEnable = gpTwoOe;
			end
			TXF_PULSE: begin
				txLevel = pulseLevel; // [R4]
				txEnable = 1'b1;
			end
			default: begin
				txLevel = 1'b1;
				txEnable = 1'b0;
			end
		endcase
	end

	// Transmit pin and pin-two input registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			optTxOut_r <= 1'b1;
			optTxOe_r <= 1'b1;
			gpTwoIn_r <= 1'b0;
		end else begin
			optTxOut_r <= txLevel;
			optTxOe_r <= txEnable;
			gpTwoIn_r <= (cfg_r.txFunc == TXF_GPIO) && txSync; // [R14]
		end
	end

	// Receive pin routing
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			uartRx_r <= 1'b1;
			gpOneIn_r <= 1'b0;
			optRxOut_r <= 1'b0;
			optRxOe_r <= 1'b0;
		end else if (cfg_r.rxFunc) begin
			uartRx_r <= 1'b1;
			gpOneIn_r <= rxSync; // [R2] [R3] [R14]
			optRxOut_r <= gpOneOut; // [R14]
			optRxOe_r <= gpOneOe;
		end else begin
			uartRx_r <= rxSync ^ cfg_r.rxInv; // [R2] [R3]
			gpOneIn_r <= 1'b0;
			optRxOut_r <= 1'b0;
			optRxOe_r <= 1'b0;
		end
	end

	// Dedicated pulse output
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			energyPulse_r <= 1'b1;
		end else begin
			energyPulse_r <= pulseLevel; // [R12]
		end
	end

	// Registered outputs
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign uartRxData = uartRx_r;
	assign gpOneIn = gpOneIn_r;
	assign gpTwoIn = gpTwoIn_r;
	assign optRxOut = optRxOut_r;
	assign optRxOe = optRxOe_r;
	assign optTxOut = optTxOut_r;
	assign optTxOe = optTxOe_r;
	assign energyPulse = energyPulse_r;
endmodule : opc_top

// ===== test/opc_ir_model.sv
`timescale 1ns/10ps
module opc_ir_model (
	input  wire logic clk,
	input  wire logic txPin,
	input  wire logic light,
	output logic      detOut,
	output int        lowCnt
);
	// Detector starts high, as an idle UART line would
	initial detOut = 1'b1;
	initial lowCnt = 0;
	// Detector output follows incoming light one cycle late
	always @(posedge clk) detOut <= light;
	// LED lit while the transmit pin is low; lit cycles counted
	always @(posedge clk) if (!txPin) lowCnt <= lowCnt + 1;
endmodule : opc_ir_model

// ===== test/opc_top_chk.sv
`timescale 1ns/10ps
`include "opc_regs.svh"
module opc_top_chk import opc_pkg::*; #(
	parameter int SAMPLE_CYCLES = 20
) (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [15:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        uartTxData,
	input wire logic        uartRxData,
	input wire logic        ceWpulse,
	input wire logic        gpOneOut,
	input wire logic        gpOneOe,
	input wire logic        gpOneIn,
	input wire logic        gpTwoOut,
	input wire logic        gpTwoOe,
	input wire logic        optRxIn,
	input wire logic        optRxOut,
	input wire logic        optRxOe,
	input wire logic        optTxOut,
	input wire logic        optTxOe,
	input wire logic        energyPulse
);
	logic       pol_r;
	logic [7:0] txSel_r, ctrl_r, lim_r, pace_r;
	int         actCnt_r;
	int         unit;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// Shadow copy of accepted register writes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{pol_r, txSel_r, ctrl_r, lim_r, pace_r} <=
				{1'b0, 16'h0000, 16'hFF00};
		end else if (psel && penable && pready && pwrite && !pslverr) begin
			case (paddr)
			{`OPC_IDX_PULSE_POL, 2'b00}: pol_r <= pwdata[6];
			{`OPC_IDX_TX_SEL, 2'b00}: txSel_r <= pwdata[7:0];
			{`OPC_IDX_OPT_CTRL, 2'b00}: ctrl_r <= pwdata[7:0];
			{`OPC_IDX_WIDTH_LIM, 2'b00}: lim_r <= pwdata[7:0];
			{`OPC_IDX_PACING, 2'b00}: pace_r <= pwdata[7:0];
			default: ;
			endcase
		end
	end
	// Cycles the energy output has stood at its active level
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) actCnt_r <= 0;
		else actCnt_r <= (energyPulse == pol_r) ? actCnt_r + 1 : 0;
	end
	assign unit = (pace_r == 8'h00 ? 1 : int'(pace_r)) * SAMPLE_CYCLES;

	chk_apb_one_wait: assert property (psel && $rose(penable) |->
		!pready ##1 pready)
		else $error("pready not in second access cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_rx_uart_inv: assert property (!$past(ctrl_r[5]) |->
		uartRxData == ($past(optRxIn, 3) ^ $past(ctrl_r[4])))
		else $error("uart receive level wrong");
	chk_gpone_in: assert property ($past(ctrl_r[5]) |->
		gpOneIn == $past(optRxIn, 3))
		else $error("pin one input wrong");
	chk_gpone_drive: assert property (optRxOe |-> $past(gpOneOe) &&
		optRxOut == $past(gpOneOut))
		else $error("pin one drive wrong");
	chk_rx_no_drive: assert property (!$past(ctrl_r[5]) |-> !optRxOe)
		else $error("receive pin driven in uart mode");
	chk_tx_gp_pass: assert property ($past(txSel_r[7:6]) == 2'b01 |->
		optTxOe == $past(gpTwoOe) && optTxOut == $past(gpTwoOut))
		else $error("pin two pass wrong");
	chk_tx_rsvd: assert property ($past(txSel_r[7:6]) == 2'b11 |->
		!optTxOe && optTxOut)
		else $error("reserved function drives pin");
	chk_tx_high: assert property ($past(txSel_r[7:6]) == 2'b00 &&
		$past(uartTxData) != $past(ctrl_r[0]) |-> optTxOut)
		else $error("high transmit interval modulated");
	chk_tx_plain: assert property ($past(txSel_r[7:6]) == 2'b00 &&
		!$past(ctrl_r[1]) |->
		optTxOut == ($past(uartTxData) ^ $past(ctrl_r[0])))
		else $error("plain transmit level wrong");
	chk_pulse_start: assert property (pace_r == 8'h00 &&
		$rose(ceWpulse) |-> ##2 energyPulse == pol_r)
		else $error("pulse not issued at once");
	chk_width_cut: assert property (lim_r != 8'hFF |->
		actCnt_r <= (2 * lim_r + 1) * unit + 4)
		else $error("pulse exceeds width limit");
	cov_pulse: cover property ($fell(energyPulse));
	cov_err: cover property (pslverr);
	cov_gpone: cover property (optRxOe);
	cov_carrier: cover property (optTxOe && !optTxOut && ctrl_r[1]);
endmodule : opc_top_chk

bind opc_top opc_top_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_chk (
	.clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
	.pready, .pslverr, .uartTxData, .uartRxData, .ceWpulse, .gpOneOut,
	.gpOneOe, .gpOneIn, .gpTwoOut, .gpTwoOe, .optRxIn, .optRxOut,
	.optRxOe, .optTxOut, .optTxOe, .energyPulse
);

// ===== test/opc_top_tb.sv
`timescale 1ns/10ps
`include "opc_regs.svh"
module opc_top_tb import opc_pkg::*;;
	localparam int SC = 20;
	logic        clk, rst_b, psel, penable, pwrite, uartTxData, ceWpulse;
	logic        gpOneOut, gpOneOe, gpTwoOut, gpTwoOe, light, act, err;
	logic        pready, pslverr, uartRxData, gpOneIn, gpTwoIn;
	logic        optRxOut, optRxOe, optTxOut, optTxOe, energyPulse, detOut;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int          fails, nCompared, lowCnt;
	// Released transmit pin is pulled up
	wire         rxPin = optRxOe ? optRxOut : detOut;
	wire         txPin = optTxOe ? optTxOut : 1'b1;

	opc_top #(.SAMPLE_CYCLES(SC), .CARRIER_W(4)) i_dut (.clk, .rst_b,
		.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .uartTxData, .uartRxData, .ceWpulse, .gpOneOut, .gpOneOe,
		.gpOneIn, .gpTwoOut, .gpTwoOe, .gpTwoIn, .optRxIn(rxPin), .optRxOut,
		.optRxOe, .optTxIn(txPin), .optTxOut, .optTxOe, .energyPulse);
	opc_ir_model i_ir (.clk, .txPin, .light, .detOut, .lowCnt);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", nCompared, fails);
		if (fails == 0 && nCompared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [13:0] idx,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fails++;
			report_and_stop();
		end
	endtask : apb

	task automatic settle;
		repeat (6) @(posedge clk);
	endtask : settle

	task automatic t_regs;
		logic [13:0] idx [5] = '{`OPC_IDX_PULSE_POL, `OPC_IDX_TX_SEL,
			`OPC_IDX_OPT_CTRL, `OPC_IDX_WIDTH_LIM, `OPC_IDX_PACING};
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, idx[i], 32'h0);
			check(rd, i == 3 ? 32'h0000_00FF : 32'h0);
		end
		apb(1'b1, `OPC_IDX_STATUS, 32'h0000_00FF);
		apb(1'b0, `OPC_IDX_STATUS, 32'h0);
		check({rd[30:0], err}, 32'h0000_000C);
		apb(1'b1, `OPC_IDX_OPT_CTRL, 32'h0000_0033);
		apb(1'b0, `OPC_IDX_OPT_CTRL, 32'h0);
		check(rd, 32'h0000_0033);
		apb(1'b0, 14'h2100, 32'h0);
		check({rd[30:0], err}, 32'h1);
		$display("register test done");
	endtask : t_regs

	// Fields: [17:16] duty, [13:12] control, [8] data, [7:0] low cycles
	task automatic t_duty;
		logic [19:0] cs [8] = '{20'h0_2008, 20'h1_2004, 20'h2_2002,
			20'h3_2001, 20'h0_2100, 20'h0_3108, 20'h0_3000, 20'h0_1110};
		int c0;
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, `OPC_IDX_TX_SEL, {30'h0, cs[i][17:16]});
			apb(1'b1, `OPC_IDX_OPT_CTRL, {30'h0, cs[i][13:12]});
			uartTxData <= cs[i][8];
			settle();
			c0 = lowCnt;
			repeat (16) @(posedge clk);
			check(lowCnt - c0, {24'h0, cs[i][7:0]});
		end
		apb(1'b1, `OPC_IDX_OPT_CTRL, 32'h0);
		$display("duty test done");
	endtask : t_duty

	task automatic t_rx;
		apb(1'b1, `OPC_IDX_OPT_CTRL, 32'h0000_0010);
		light <= 1'b0;
		settle();
		check({29'h0, uartRxData, gpOneIn, optRxOe}, 32'h4);
		light <= 1'b1;
		settle();
		check({29'h0, uartRxData, gpOneIn, optRxOe}, 32'h0);
		apb(1'b1, `OPC_IDX_OPT_CTRL, 32'h0000_0030);
		light <= 1'b0;
		settle();
		check({30'h0, gpOneIn, optRxOe}, 32'h0);
		light <= 1'b1;
		settle();
		check({30'h0, gpOneIn, optRxOe}, 32'h2);
		gpOneOe <= 1'b1;
		settle();
		check({29'h0, gpOneIn, optRxOe, optRxOut}, 32'h2);
		gpOneOe <= 1'b0;
		apb(1'b1, `OPC_IDX_OPT_CTRL, 32'h0);
		$display("receive test done");
	endtask : t_rx

	task automatic t_txsel;
		apb(1'b1, `OPC_IDX_TX_SEL, 32'h0000_0040);
		gpTwoOe <= 1'b1;
		settle();
		check({29'h0, gpTwoIn, optTxOe, optTxOut}, 32'h2);
		gpTwoOe <= 1'b0;
		settle();
		check({30'h0, gpTwoIn, optTxOe}, 32'h2);
		apb(1'b1, `OPC_IDX_TX_SEL, 32'h0000_00C0);
		settle();
		check({30'h0, optTxOe, optTxOut}, 32'h1);
		apb(1'b1, `OPC_IDX_TX_SEL, 32'h0000_0080);
		settle();
		check({29'h0, optTxOe, optTxOut, energyPulse}, 32'h7);
		$display("transmit select test done");
	endtask : t_txsel

	// Raise a request, then time the active phase of the pulse
	task automatic pulse(input logic [7:0] lim, input int lo, input int hi,
		input int cap);
		int k;
		apb(1'b1, `OPC_IDX_WIDTH_LIM, {24'h0, lim});
		ceWpulse <= 1'b1;
		repeat (3) @(posedge clk);
		check(32'(energyPulse), 32'(act));
		k = 0;
		while (energyPulse === act && k < cap) begin
			@(posedge clk);
			k++;
		end
		check(32'(k >= lo && k <= hi), 32'h1);
		ceWpulse <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : pulse

	task automatic t_pulse;
		int k;
		pulse(8'h00, 1, SC + 2, SC + 3);
		pulse(8'h02, 4 * SC - 2, 5 * SC + 2, 5 * SC + 3);
		pulse(8'hFF, 300, 300, 300);
		apb(1'b1, `OPC_IDX_PULSE_POL, 32'h0000_0040);
		act <= 1'b1;
		pulse(8'h00, 1, SC + 2, SC + 3);
		apb(1'b1, `OPC_IDX_PACING, 32'h0000_0051);
		ceWpulse <= 1'b1;
		apb(1'b0, `OPC_IDX_STATUS, 32'h0);
		check(rd, 32'h0000_0012);
		k = 0;
		while (energyPulse !== act && k < 81 * SC + 40) begin
			@(posedge clk);
			k++;
		end
		check(32'(energyPulse), 32'(act));
		ceWpulse <= 1'b0;
		$display("pulse test done");
	endtask : t_pulse

	initial begin
		{rst_b, psel, penable, pwrite, ceWpulse, act} = 6'h00;
		{gpOneOut, gpOneOe, gpTwoOut, gpTwoOe} = 4'h0;
		{uartTxData, light} = 2'h3;
		paddr = 16'h0000;
		pwdata = 32'h0;
		fails = 0;
		nCompared = 0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_duty();
		t_rx();
		t_txsel();
		t_pulse();
		report_and_stop();
	end
endmodule : opc_top_tb
